// ### hw/spbs_ctrl.sv
// Our own choices: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
module spbs_ctrl #(
    parameter int ROM_KB = 16
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [15:0] cpu_fetch_addr,
    output logic [15:0] flash_phys_addr,
    output logic [15:0] debug_option_addr,
    input wire logic debug_active,
    input wire logic debug_programming,
    input wire logic stop_mode,
    input wire logic irq_pending,
    input wire logic irq_enabled,
    output logic irq_vector_req,
    output spbs_pkg::spbs_flash_op_type flash_op,
    output logic flash_busy,
    input wire logic flash_done,
    output logic int_osc_enable,
    output spbs_pkg::spbs_clk_src_type target_clk_sel,
    output spbs_pkg::spbs_emu_freq_type emu_freq_sel,
    input spbs_pkg::spbs_pin_drive_type user_osc_pins,
    input spbs_pkg::spbs_pin_drive_type user_port_pins,
    input spbs_pkg::spbs_pin_drive_type debug_pins,
    output spbs_pkg::spbs_pin_drive_type osc_pin_drive,
    output spbs_pkg::spbs_pin_drive_type port3_pin_drive
);
    typedef enum logic [1:0] {
        SEQ_IDLE,
        SEQ_RUN,
        SEQ_SUSPEND
    } spbs_seq_type;

    localparam logic SWAP_ALLOWED = (ROM_KB != spbs_pkg::ROM_KB_SMALL);

    logic [7:0] mode_ctrl_q;
    logic rewrite_mode_select;
    logic swap_req_q;
    logic swap_active_q;
    logic boot_seen_q;
    logic dbg_pair_q;
    spbs_pkg::spbs_clk_src_type dbg_clk_q;
    spbs_pkg::spbs_emu_freq_type emu_freq_q;
    spbs_seq_type seq_q;
    spbs_pkg::spbs_flash_op_type pend_op_q;
    logic aw_hold_q, w_hold_q;
    logic [7:0] aw_addr_q;
    logic [31:0] w_data_q;
    logic [3:0] w_strb_q;
    logic wr_fire;
    logic rd_fire;
    logic wr_ok;
    logic [31:0] rd_word;
    logic rd_ok;
    logic own_osc, own_port;

    assign rewrite_mode_select = mode_ctrl_q[spbs_pkg::MODE_BIT];
    assign wr_fire = aw_hold_q && w_hold_q && !s_axi_bvalid;
    assign rd_fire = s_axi_arvalid && s_axi_arready;

    // write address and data captured independently
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold_q <= 1'b0;
            w_hold_q <= 1'b0;
            aw_addr_q <= 8'h00;
            w_data_q <= 32'h0000_0000;
            w_strb_q <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_hold_q <= 1'b1;
                aw_addr_q <= s_axi_awaddr;
            end else if (wr_fire) begin
                aw_hold_q <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_hold_q <= 1'b1;
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
            end else if (wr_fire) begin
                w_hold_q <= 1'b0;
            end
        end
    end

    always_comb begin
        unique case (aw_addr_q)
            spbs_pkg::ADDR_MODE_CTRL, spbs_pkg::ADDR_BOOT_CTRL, spbs_pkg::ADDR_DBG_CTRL,
            spbs_pkg::ADDR_STATUS, spbs_pkg::ADDR_FLASH_CMD: wr_ok = 1'b1;
            default: wr_ok = 1'b0;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= spbs_pkg::RESP_OKAY;
        end else begin
            s_axi_awready <= !aw_hold_q && !(s_axi_awvalid && s_axi_awready);
            s_axi_wready <= !w_hold_q && !(s_axi_wvalid && s_axi_wready);
            if (wr_fire) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_ok ? spbs_pkg::RESP_OKAY : spbs_pkg::RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // mode control register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mode_ctrl_q <= spbs_pkg::MODE_CTRL_RESET;
        end else if (wr_fire && aw_addr_q == spbs_pkg::ADDR_MODE_CTRL && w_strb_q[0]) begin
            mode_ctrl_q <= w_data_q[7:0] & spbs_pkg::MODE_CTRL_MASK;
        end
    end

    // swap request is recorded now, takes effect at next reset
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            boot_seen_q <= 1'b0;
            swap_active_q <= 1'b0;
        end else if (!boot_seen_q) begin
            boot_seen_q <= 1'b1;
            swap_active_q <= swap_req_q && SWAP_ALLOWED;
        end
    end

    // recorded swap setting survives system reset (non-volatile info)
    always_ff @(posedge aclk) begin
        if (wr_fire && aw_addr_q == spbs_pkg::ADDR_BOOT_CTRL && w_strb_q[0]) begin
            swap_req_q <= w_data_q[spbs_pkg::BOOT_SWAP_REQ_BIT] && SWAP_ALLOWED;
        end
    end

    // debug configuration
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            dbg_pair_q <= 1'b0;
            dbg_clk_q <= spbs_pkg::CLK_INT_OSC;
            emu_freq_q <= spbs_pkg::EMU_4MHZ;
        end else if (wr_fire && aw_addr_q == spbs_pkg::ADDR_DBG_CTRL && w_strb_q[0]) begin
            dbg_pair_q <= w_data_q[spbs_pkg::DBG_PAIR_BIT];
            if (w_data_q[spbs_pkg::DBG_CLK_LSB +: 2] != 2'h3) begin
                dbg_clk_q <= spbs_pkg::spbs_clk_src_type'(w_data_q[spbs_pkg::DBG_CLK_LSB +: 2]);
            end
            if (w_data_q[spbs_pkg::DBG_EMU_FREQ_LSB +: 2] != 2'h3) begin
                emu_freq_q <= spbs_pkg::spbs_emu_freq_type'(w_data_q[spbs_pkg::DBG_EMU_FREQ_LSB +: 2]);
            end
        end
    end

    // flash sequence with interrupt suspend
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            seq_q <= SEQ_IDLE;
            pend_op_q <= '0;
            flash_op <= '0;
            flash_busy <= 1'b0;
            irq_vector_req <= 1'b0;
        end else begin
            irq_vector_req <= 1'b0;
            unique case (seq_q)
                SEQ_IDLE: begin
                    flash_op <= '0;
                    if (wr_fire && aw_addr_q == spbs_pkg::ADDR_FLASH_CMD && w_strb_q[0]
                        && rewrite_mode_select) begin
                        pend_op_q.flash_write <= w_data_q[spbs_pkg::CMD_WRITE_BIT];
                        pend_op_q.flash_erase <= w_data_q[spbs_pkg::CMD_ERASE_BIT];
                        pend_op_q.cluster1 <= 1'b0;
                        seq_q <= SEQ_RUN;
                        flash_busy <= 1'b1;
                    end
                end
                SEQ_RUN: begin
                    if (!rewrite_mode_select) begin
                        flash_op <= '0;
                        seq_q <= SEQ_IDLE;
                        flash_busy <= 1'b0;
                    end else if (irq_pending && irq_enabled) begin
                        flash_op <= '0;
                        irq_vector_req <= 1'b1;
                        seq_q <= SEQ_SUSPEND;
                    end else if (flash_done) begin
                        flash_op <= '0;
                        seq_q <= SEQ_IDLE;
                        flash_busy <= 1'b0;
                    end else begin
                        flash_op <= pend_op_q;
                    end
                end
                SEQ_SUSPEND: begin
                    flash_op <= '0;
                    if (!rewrite_mode_select) begin
                        seq_q <= SEQ_IDLE;
                        flash_busy <= 1'b0;
                    end else if (wr_fire && aw_addr_q == spbs_pkg::ADDR_FLASH_CMD && w_strb_q[0]
                                 && w_data_q[spbs_pkg::CMD_RESUME_BIT]) begin
                        seq_q <= SEQ_RUN;
                    end
                end
                default: seq_q <= SEQ_IDLE;
            endcase
        end
    end

    // address swap of the two boot clusters
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            flash_phys_addr <= 16'h0000;
            debug_option_addr <= spbs_pkg::DBG_OPT_ADDR;
        end else begin
            flash_phys_addr <= cpu_fetch_addr;
            if (swap_active_q && cpu_fetch_addr[15:spbs_pkg::CLUSTER_ADDR_BIT+1] == '0) begin
                flash_phys_addr[spbs_pkg::CLUSTER_ADDR_BIT] <= !cpu_fetch_addr[spbs_pkg::CLUSTER_ADDR_BIT];
            end
            debug_option_addr <= swap_active_q ? spbs_pkg::DBG_OPT_ADDR_SWAP : spbs_pkg::DBG_OPT_ADDR;
        end
    end

    // clock selection
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            target_clk_sel <= spbs_pkg::CLK_INT_OSC;
            emu_freq_sel <= spbs_pkg::EMU_4MHZ;
            int_osc_enable <= 1'b1;
        end else begin
            target_clk_sel <= debug_programming ? spbs_pkg::CLK_INT_OSC : dbg_clk_q;
            emu_freq_sel <= emu_freq_q;
            int_osc_enable <= !stop_mode || debug_active;
        end
    end

    assign own_osc = debug_active && !dbg_pair_q;
    assign own_port = debug_active && dbg_pair_q;

    spbs_pin_mux u_osc_mux (
        .aclk(aclk),
        .aresetn(aresetn),
        .debug_own(own_osc),
        .user_drive(user_osc_pins),
        .debug_drive(debug_pins),
        .pin_drive(osc_pin_drive)
    );

    spbs_pin_mux u_port_mux (
        .aclk(aclk),
        .aresetn(aresetn),
        .debug_own(own_port),
        .user_drive(user_port_pins),
        .debug_drive(debug_pins),
        .pin_drive(port3_pin_drive)
    );

    // read path
    always_comb begin
        rd_word = 32'h0000_0000;
        rd_ok = 1'b1;
        unique case (s_axi_araddr)
            spbs_pkg::ADDR_MODE_CTRL: rd_word[7:0] = mode_ctrl_q;
            spbs_pkg::ADDR_BOOT_CTRL: rd_word[1:0] = {swap_active_q, swap_req_q};
            spbs_pkg::ADDR_DBG_CTRL: rd_word[4:0] = {emu_freq_q, dbg_clk_q, dbg_pair_q};
            spbs_pkg::ADDR_STATUS: rd_word[3:0] = {SWAP_ALLOWED, seq_q == SEQ_SUSPEND, flash_busy,
                                                   rewrite_mode_select};
            spbs_pkg::ADDR_FLASH_CMD: rd_word = 32'h0000_0000;
            default: rd_ok = 1'b0;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= spbs_pkg::RESP_OKAY;
        end else begin
            s_axi_arready <= !s_axi_rvalid && !rd_fire;
            if (rd_fire) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_word;
                s_axi_rresp <= rd_ok ? spbs_pkg::RESP_OKAY : spbs_pkg::RESP_SLVERR;
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end
endmodule : spbs_ctrl

// ### hw/spbs_pin_mux.sv
`timescale 1ns/1ps
// one shared pin pair: user drive or debug drive
module spbs_pin_mux (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic debug_own,
    input spbs_pkg::spbs_pin_drive_type user_drive,
    input spbs_pkg::spbs_pin_drive_type debug_drive,
    output spbs_pkg::spbs_pin_drive_type pin_drive
);
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pin_drive <= '0;
        end else if (debug_own) begin
            pin_drive <= debug_drive;
        end else begin
            pin_drive <= user_drive;
        end
    end
endmodule : spbs_pin_mux

// ### shared/spbs_pkg.sv
package spbs_pkg;
    // register map (byte addresses, one aligned word each)
    localparam logic [7:0] ADDR_MODE_CTRL = 8'h00;
    localparam logic [7:0] ADDR_BOOT_CTRL = 8'h04;
    localparam logic [7:0] ADDR_DBG_CTRL = 8'h08;
    localparam logic [7:0] ADDR_STATUS = 8'h0C;
    localparam logic [7:0] ADDR_FLASH_CMD = 8'h10;
    // mode control fields
    localparam int MODE_BIT = 0;
    localparam logic [7:0] MODE_CTRL_RESET = 8'h00;
    localparam logic [7:0] MODE_CTRL_MASK = 8'h01;
    // boot control fields
    localparam int BOOT_SWAP_REQ_BIT = 0;
    // debug control fields
    localparam int DBG_PAIR_BIT = 0;
    localparam int DBG_CLK_LSB = 1;
    localparam int DBG_EMU_FREQ_LSB = 3;
    // flash command fields
    localparam int CMD_WRITE_BIT = 0;
    localparam int CMD_ERASE_BIT = 1;
    localparam int CMD_RESUME_BIT = 2;
    // cluster geometry, option addresses, ROM size and response codes
    localparam int CLUSTER_BYTES = 4096;
    localparam int CLUSTER_ADDR_BIT = 12;
    localparam logic [15:0] DBG_OPT_ADDR = 16'h0084;
    localparam logic [15:0] DBG_OPT_ADDR_SWAP = 16'h1084;
    localparam int ROM_KB_SMALL = 4;
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    typedef enum logic [1:0] {
        CLK_ADAPTER,
        CLK_EMULATOR,
        CLK_INT_OSC
    } spbs_clk_src_type;

    typedef enum logic [1:0] {
        EMU_4MHZ,
        EMU_8MHZ,
        EMU_16MHZ
    } spbs_emu_freq_type;

    typedef struct packed {
        logic clk_o;
        logic clk_oe;
        logic dat_o;
        logic dat_oe;
    } spbs_pin_drive_type;

    typedef struct packed {
        logic flash_write;
        logic flash_erase;
        logic cluster1;
    } spbs_flash_op_type;
endpackage : spbs_pkg

// ### tb/spbs_ctrl_properties.sv
`timescale 1ns/1ps
module spbs_ctrl_properties (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [15:0] cpu_fetch_addr,
    input wire logic [15:0] flash_phys_addr,
    input wire logic [15:0] debug_option_addr,
    input wire logic debug_active,
    input wire logic debug_programming,
    input wire logic stop_mode,
    input wire logic irq_pending,
    input wire logic irq_enabled,
    input wire logic irq_vector_req,
    input wire logic int_osc_enable,
    input spbs_pkg::spbs_clk_src_type target_clk_sel,
    input spbs_pkg::spbs_pin_drive_type user_osc_pins,
    input spbs_pkg::spbs_pin_drive_type user_port_pins,
    input spbs_pkg::spbs_pin_drive_type debug_pins,
    input spbs_pkg::spbs_pin_drive_type osc_pin_drive,
    input spbs_pkg::spbs_pin_drive_type port3_pin_drive
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // pin owner and all pin requests unchanged for three cycles
    sequence s_steady(act);
        (act && $stable(debug_pins) && $stable(user_osc_pins) && $stable(user_port_pins)) [*3];
    endsequence
    sequence s_opt_held(logic [15:0] v);
        debug_option_addr == v ##1 debug_option_addr == v;
    endsequence

    chk_debug_owns_pair: assert property (
        s_steady(debug_active) |-> osc_pin_drive == debug_pins || port3_pin_drive == debug_pins)
        else $error("debug pins not routed to a pair");
    chk_user_pins_pass: assert property (
        s_steady(!debug_active) |-> osc_pin_drive == user_osc_pins && port3_pin_drive == user_port_pins)
        else $error("user pin drive lost outside debug");
    chk_swap_remap: assert property (
        debug_option_addr == spbs_pkg::DBG_OPT_ADDR_SWAP && cpu_fetch_addr < 16'h2000
        |=> flash_phys_addr == ($past(cpu_fetch_addr) ^ 16'h1000))
        else $error("swapped cluster address wrong");
    chk_plain_map: assert property (
        s_opt_held(spbs_pkg::DBG_OPT_ADDR) |-> flash_phys_addr == $past(cpu_fetch_addr))
        else $error("unswapped address altered");
    chk_osc_stop: assert property (
        stop_mode && !debug_active |=> !int_osc_enable)
        else $error("oscillator kept in stop");
    chk_osc_debug: assert property (
        debug_active |=> int_osc_enable)
        else $error("oscillator stopped while debugging");
    chk_prog_clock: assert property (
        debug_programming |=> target_clk_sel == spbs_pkg::CLK_INT_OSC)
        else $error("programming clock not internal");
    chk_irq_pulse: assert property (
        irq_vector_req |-> $past(irq_pending) && $past(irq_enabled) ##1 !irq_vector_req)
        else $error("vector request without cause or too long");
endmodule : spbs_ctrl_properties

bind spbs_ctrl spbs_ctrl_properties i_chk (.*);

// ### tb/spbs_flash_model.sv
`timescale 1ns/1ps
// flash array stand-in: finishes each write or erase after lat+1 busy cycles
module spbs_flash_model (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [3:0] lat,
    input wire logic flash_busy,
    input spbs_pkg::spbs_flash_op_type flash_op,
    output logic flash_done,
    output int n_ops
);
    logic [3:0] cnt_q;
    logic run;
    assign run = flash_busy && (flash_op.flash_write || flash_op.flash_erase) && !flash_done;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt_q <= 4'h0;
            flash_done <= 1'h0;
            n_ops <= 0;
        end else if (run && cnt_q == lat) begin
            cnt_q <= 4'h0;
            flash_done <= 1'h1;
            n_ops <= n_ops + 1;
        end else begin
            cnt_q <= run ? cnt_q + 4'h1 : 4'h0;
            flash_done <= 1'h0;
        end
    end
endmodule : spbs_flash_model

// ### tb/test_spbs_ctrl.sv
`timescale 1ns/1ps
module test_spbs_ctrl;
    logic aclk = 1'h0, aresetn = 1'h0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rdat;
    logic [3:0] s_axi_wstrb = 4'hF, lat = 4'h1;
    logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0;
    logic s_axi_rready = 1'h0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, resp;
    logic [15:0] cpu_fetch_addr = 16'h0, flash_phys_addr, debug_option_addr;
    logic debug_active = 1'h0, debug_programming = 1'h0, stop_mode = 1'h0, irq_pending = 1'h0;
    logic irq_enabled = 1'h0, irq_vector_req, flash_busy, flash_done, int_osc_enable;
    spbs_pkg::spbs_flash_op_type flash_op;
    spbs_pkg::spbs_clk_src_type target_clk_sel;
    spbs_pkg::spbs_emu_freq_type emu_freq_sel;
    spbs_pkg::spbs_pin_drive_type user_osc_pins = 4'h5, user_port_pins = 4'hA, debug_pins = 4'h3;
    spbs_pkg::spbs_pin_drive_type osc_pin_drive, port3_pin_drive;
    int n_ops, n_fail = 0, n_tests = 0;

    spbs_ctrl i_dut (.*);
    spbs_flash_model i_flash (.*);

    always #12.5 aclk = ~aclk;

    task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            n_fail++;
            $display("ERROR %s expected %h got %h", s, e, g);
        end
    endtask : chk

    task automatic settle;
        repeat (3) @(posedge aclk);
    endtask : settle

    task automatic rst;
        aresetn <= 1'h0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'h1;
    endtask : rst

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        do begin
            @(posedge aclk);
            if (s_axi_awready)
                s_axi_awvalid <= 1'h0;
            if (s_axi_wready)
                s_axi_wvalid <= 1'h0;
        end while (!s_axi_bvalid);
        resp = s_axi_bresp;
        s_axi_bready <= 1'h0;
    endtask : wr

    task automatic rd(input logic [7:0] a);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        do begin
            @(posedge aclk);
            if (s_axi_arready)
                s_axi_arvalid <= 1'h0;
        end while (!s_axi_rvalid);
        rdat = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 1'h0;
    endtask : rd

    task automatic wait_ops(input int n);
        for (int i = 0; i < 80 && n_ops < n; i++)
            @(posedge aclk);
    endtask : wait_ops

    task automatic t_regs;
        rd(spbs_pkg::ADDR_MODE_CTRL);
        chk("mode_reset", 32'h0, rdat);
        wr(spbs_pkg::ADDR_MODE_CTRL, 32'hFFFF_FFFF);
        chk("mode_wresp", 32'(spbs_pkg::RESP_OKAY), 32'(resp));
        rd(spbs_pkg::ADDR_MODE_CTRL);
        chk("mode_set", 32'h1, rdat);
        wr(spbs_pkg::ADDR_MODE_CTRL, 32'hFE);
        rd(spbs_pkg::ADDR_MODE_CTRL);
        chk("mode_clear", 32'h0, rdat);
        s_axi_wstrb <= 4'hE;
        wr(spbs_pkg::ADDR_MODE_CTRL, 32'h1);
        s_axi_wstrb <= 4'hF;
        rd(spbs_pkg::ADDR_MODE_CTRL);
        chk("mode_strb", 32'h0, rdat);
        rd(8'h14);
        chk("unmapped_resp", 32'(spbs_pkg::RESP_SLVERR), 32'(resp));
        wr(8'h14, 32'h1);
        chk("unmapped_wresp", 32'(spbs_pkg::RESP_SLVERR), 32'(resp));
    endtask : t_regs

    task automatic t_flash;
        int n0 = n_ops;
        wr(spbs_pkg::ADDR_FLASH_CMD, 32'h1);
        repeat (20) @(posedge aclk);
        chk("ops_locked", n0, n_ops);
        wr(spbs_pkg::ADDR_MODE_CTRL, 32'h1);
        wr(spbs_pkg::ADDR_FLASH_CMD, 32'h2);
        wait_ops(n0 + 1);
        chk("ops_erase", n0 + 1, n_ops);
        lat <= 4'hF;
        wr(spbs_pkg::ADDR_FLASH_CMD, 32'h1);
        irq_enabled <= 1'h1;
        irq_pending <= 1'h1;
        for (int i = 0; i < 20 && irq_vector_req !== 1'h1; i++)
            @(posedge aclk);
        chk("irq_vector", 32'h1, 32'(irq_vector_req));
        irq_pending <= 1'h0;
        rd(spbs_pkg::ADDR_STATUS);
        chk("suspended", 32'h4, rdat & 32'h4);
        chk("swap_allowed", 32'h8, rdat & 32'h8);
        wr(spbs_pkg::ADDR_FLASH_CMD, 32'h4);
        wait_ops(n0 + 2);
        chk("resumed", n0 + 2, n_ops);
        wr(spbs_pkg::ADDR_MODE_CTRL, 32'h0);
    endtask : t_flash

    task automatic t_debug;
        debug_active <= 1'h1;
        settle();
        chk("osc_debug", 32'(debug_pins), 32'(osc_pin_drive));
        chk("port_user", 32'(user_port_pins), 32'(port3_pin_drive));
        stop_mode <= 1'h1;
        settle();
        chk("osc_on", 32'h1, 32'(int_osc_enable));
        debug_active <= 1'h0;
        settle();
        chk("osc_off", 32'h0, 32'(int_osc_enable));
        stop_mode <= 1'h0;
        wr(spbs_pkg::ADDR_DBG_CTRL, 32'h1);
        debug_active <= 1'h1;
        settle();
        chk("port_debug", 32'(debug_pins), 32'(port3_pin_drive));
        chk("osc_user", 32'(user_osc_pins), 32'(osc_pin_drive));
        for (int s = 0; s < 3; s++) begin
            wr(spbs_pkg::ADDR_DBG_CTRL, (s << 3) | (s << 1));
            settle();
            chk("clk_src", s, 32'(target_clk_sel));
            chk("emu_freq", s, 32'(emu_freq_sel));
        end
        wr(spbs_pkg::ADDR_DBG_CTRL, 32'h0);
        debug_programming <= 1'h1;
        settle();
        chk("prog_clk", 32'(spbs_pkg::CLK_INT_OSC), 32'(target_clk_sel));
        debug_programming <= 1'h0;
        debug_active <= 1'h0;
    endtask : t_debug

    task automatic t_swap;
        logic [15:0] fa[3] = '{16'h0123, 16'h1ABC, 16'h3456};
        logic [15:0] fe[3] = '{16'h1123, 16'h0ABC, 16'h3456};
        wr(spbs_pkg::ADDR_MODE_CTRL, 32'h1);
        wr(spbs_pkg::ADDR_BOOT_CTRL, 32'h1);
        rst();
        rd(spbs_pkg::ADDR_MODE_CTRL);
        chk("mode_after_reset", 32'h0, rdat);
        rd(spbs_pkg::ADDR_BOOT_CTRL);
        chk("swap_active", 32'h2, rdat & 32'h2);
        chk("opt_swapped", 32'(spbs_pkg::DBG_OPT_ADDR_SWAP), 32'(debug_option_addr));
        for (int i = 0; i < 3; i++) begin
            cpu_fetch_addr <= fa[i];
            settle();
            chk("remap", 32'(fe[i]), 32'(flash_phys_addr));
        end
        wr(spbs_pkg::ADDR_BOOT_CTRL, 32'h0);
        rst();
        cpu_fetch_addr <= 16'h0123;
        settle();
        chk("opt_plain", 32'(spbs_pkg::DBG_OPT_ADDR), 32'(debug_option_addr));
        chk("map_plain", 32'h0123, 32'(flash_phys_addr));
    endtask : t_swap

    task automatic final_report;
        if (n_fail == 0 && n_tests > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : final_report

    initial begin
        rst();
        // swap record is non-volatile: give it a known value first
        wr(spbs_pkg::ADDR_BOOT_CTRL, 32'h0);
        rst();
        t_regs();
        t_flash();
        t_debug();
        t_swap();
        final_report();
    end

    initial begin
        #200us;
        n_fail++;
        final_report();
    end
endmodule : test_spbs_ctrl
